// *** verilog/spl_core.sv ***
// Purpose: system pll configuration registers and lock supervision
// Assumes: boot loader presents otp or eeprom contents in the first cycle after reset
// Notes: analog core, reference input stage not included
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module spl_core
    import spl_pkg::*;
#(
    parameter int LOCK_QUAL_CYC = SPL_LOCK_QUAL_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // boot configuration sources
    input wire logic otp_en,
    input wire logic otp_valid,
    input wire logic [11:0] otp_ctrl,
    input wire logic eeprom_en,
    input wire logic eeprom_valid,
    input wire logic [11:0] eeprom_ctrl,
    // analog pll side, control voltage from an on-chip adc
    input wire logic [11:0] vc_code,
    output logic pll_doubler_en,
    output logic [9:0] pll_fb_div,
    output logic fod_clk_en,
    // alarms
    output logic lol_gpio,
    output logic irq
);

    spl_ctrl_t ctrl_r;
    spl_freq_t freq_r;
    spl_state_t state_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic [1:0] cfg_src_r;
    logic [15:0] qual_cnt_r;
    logic locked_r;
    logic boot_done_r;
    logic [11:0] vc_lo;
    logic [11:0] vc_hi;
    logic vc_ok;
    logic wr_en;
    logic ctrl_wr;
    logic [2:0] ev;
    logic lock_prev_r;
    logic [31:0] rd_mux;

    function automatic logic div_ok(input logic [9:0] d);
        div_ok = (d >= SPL_FBDIV_MIN) && (d <= SPL_FBDIV_MAX);
    endfunction : div_ok

    function automatic spl_ctrl_t to_ctrl(input logic [11:0] w);
        to_ctrl.fb_div = w[9:0];
        to_ctrl.doubler_en = w[10];
        to_ctrl.gpio_route = w[11];
    endfunction : to_ctrl

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    // out-of-range divider writes are refused, keeps the loop sane
    assign ctrl_wr = wr_en && (paddr == SPL_OFS_CTRL) && boot_done_r
        && div_ok(pwdata[SPL_CTRL_DIV_LSB +: 10]);

    // boot load then host control
    always_ff @(posedge mclk) begin
        if (rst) begin
            boot_done_r <= 1'b0;
            ctrl_r <= '{1'b0, 1'b0, SPL_FBDIV_RST};
            cfg_src_r <= 2'b00;
        end else if (!boot_done_r) begin
            boot_done_r <= 1'b1;
            if (otp_en && otp_valid && div_ok(otp_ctrl[9:0])) begin
                ctrl_r <= to_ctrl(otp_ctrl);
                cfg_src_r <= 2'b01;
            end else if (eeprom_en && eeprom_valid
                && div_ok(eeprom_ctrl[9:0])) begin
                ctrl_r <= to_ctrl(eeprom_ctrl);
                cfg_src_r <= 2'b10;
            end
        end else if (ctrl_wr) begin
            ctrl_r.fb_div <= pwdata[SPL_CTRL_DIV_LSB +: 10];
            ctrl_r.doubler_en <= pwdata[SPL_CTRL_DBL_BIT];
            ctrl_r.gpio_route <= pwdata[SPL_CTRL_GPIO_BIT];
        end
    end

    // frequency word registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            freq_r <= '0;
        end else if (wr_en) begin
            case (paddr)
                SPL_OFS_FREQ_M_LO: freq_r.num[31:0] <= pwdata;
                SPL_OFS_FREQ_M_HI: freq_r.num[47:32] <= pwdata[15:0];
                SPL_OFS_FREQ_N: freq_r.den <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // limits scale with the vco setting, no user threshold
    always_comb begin
        vc_lo = SPL_VC_BASE - {4'h0, ctrl_r.fb_div[9:2]};
        vc_hi = SPL_VC_BASE + SPL_VC_SPAN - {3'h0, ctrl_r.fb_div[9:1]}
            - (ctrl_r.doubler_en ? 12'h040 : 12'h000);
        vc_ok = (vc_code >= vc_lo) && (vc_code <= vc_hi);
    end

    // lock supervision
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= SPL_ST_LOAD;
            qual_cnt_r <= '0;
            locked_r <= 1'b0;
        end else if (ctrl_wr || !boot_done_r) begin
            state_r <= SPL_ST_WAIT;
            qual_cnt_r <= '0;
            locked_r <= 1'b0;
        end else begin
            case (state_r)
                SPL_ST_LOAD: begin
                    state_r <= SPL_ST_WAIT;
                end
                SPL_ST_WAIT: begin
                    if (!vc_ok) begin
                        qual_cnt_r <= '0;
                    end else if (qual_cnt_r == 16'(LOCK_QUAL_CYC - 1)) begin
                        state_r <= SPL_ST_LOCKED;
                        locked_r <= 1'b1;
                    end else begin
                        qual_cnt_r <= qual_cnt_r + 16'h0001;
                    end
                end
                SPL_ST_LOCKED: begin
                    if (!vc_ok) begin
                        state_r <= SPL_ST_WAIT;
                        locked_r <= 1'b0;
                        qual_cnt_r <= '0;
                    end
                end
                default: state_r <= SPL_ST_WAIT;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            lock_prev_r <= 1'b0;
        end else begin
            lock_prev_r <= locked_r;
        end
    end

    assign ev[SPL_IRQ_LOL] = lock_prev_r && !locked_r;
    assign ev[SPL_IRQ_LOCK] = !lock_prev_r && locked_r;
    assign ev[SPL_IRQ_BADDIV] = wr_en && (paddr == SPL_OFS_CTRL)
        && !div_ok(pwdata[SPL_CTRL_DIV_LSB +: 10]);

    // sticky status, set beats clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            if (wr_en && paddr == SPL_OFS_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~pwdata[2:0]) | ev;
            end else begin
                irq_stat_r <= irq_stat_r | ev;
            end
            if (wr_en && paddr == SPL_OFS_IRQ_MASK) begin
                irq_mask_r <= pwdata[2:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq <= 1'b0;
            lol_gpio <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_mask_r);
            lol_gpio <= ctrl_r.gpio_route && !locked_r;
        end
    end

    // reference is the crystal; outputs steer the analog core
    assign pll_doubler_en = ctrl_r.doubler_en;
    assign pll_fb_div = ctrl_r.fb_div;
    assign fod_clk_en = locked_r;

    // apb read mux, unmapped reads zero with error
    always_comb begin
        rd_mux = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            SPL_OFS_CTRL: rd_mux = {14'h0, ctrl_r.gpio_route,
                ctrl_r.doubler_en, 6'h0, ctrl_r.fb_div};
            SPL_OFS_LOCK: rd_mux = {30'h0, !locked_r, locked_r};
            SPL_OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
            SPL_OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_r};
            SPL_OFS_FREQ_M_LO: rd_mux = freq_r.num[31:0];
            SPL_OFS_FREQ_M_HI: rd_mux = {16'h0, freq_r.num[47:32]};
            SPL_OFS_FREQ_N: rd_mux = {16'h0, freq_r.den};
            SPL_OFS_CFG_SRC: rd_mux = {30'h0, cfg_src_r};
            default: pslverr = psel && penable;
        endcase
    end

    // latched in setup so read data leaves a flop, pready stays high
    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= rd_mux;
        end
    end

    property p_lock_after_reconfig;
        @(posedge mclk) disable iff (rst)
        ctrl_wr |=> !locked_r;
    endproperty
    a_lock_after_reconfig: assert property (p_lock_after_reconfig)
        else $error("lock kept across reconfiguration");

    property p_div_range;
        @(posedge mclk) disable iff (rst)
        boot_done_r |-> div_ok(ctrl_r.fb_div);
    endproperty
    a_div_range: assert property (p_div_range)
        else $error("feedback divider out of range");

    property p_lock_needs_vc;
        @(posedge mclk) disable iff (rst)
        locked_r && !vc_ok |=> !locked_r;
    endproperty
    a_lock_needs_vc: assert property (p_lock_needs_vc)
        else $error("lock held with control voltage out of limits");

    property p_lol_event;
        @(posedge mclk) disable iff (rst)
        $fell(locked_r) |=> irq_stat_r[SPL_IRQ_LOL];
    endproperty
    a_lol_event: assert property (p_lol_event)
        else $error("loss of lock not flagged");

    property p_gpio;
        @(posedge mclk) disable iff (rst)
        ##1 lol_gpio == $past(ctrl_r.gpio_route && !locked_r);
    endproperty
    a_gpio: assert property (p_gpio)
        else $error("gpio alarm mismatch");

    property p_fod;
        @(posedge mclk) disable iff (rst)
        fod_clk_en == locked_r;
    endproperty
    a_fod: assert property (p_fod)
        else $error("fod enable not tied to lock");

    property p_dbl;
        @(posedge mclk) disable iff (rst)
        ctrl_wr |=> pll_doubler_en == $past(pwdata[SPL_CTRL_DBL_BIT]);
    endproperty
    a_dbl: assert property (p_dbl)
        else $error("doubler select not applied");

    property p_freq_n;
        @(posedge mclk) disable iff (rst)
        wr_en && paddr == SPL_OFS_FREQ_N |=> freq_r.den == $past(pwdata[15:0]);
    endproperty
    a_freq_n: assert property (p_freq_n)
        else $error("denominator not stored");

    property p_boot_otp;
        @(posedge mclk) disable iff (rst)
        !boot_done_r && otp_en && otp_valid && div_ok(otp_ctrl[9:0])
            |=> cfg_src_r == 2'b01 && pll_fb_div == $past(otp_ctrl[9:0]);
    endproperty
    a_boot_otp: assert property (p_boot_otp)
        else $error("boot did not take the otp word");

    property p_boot_rom;
        @(posedge mclk) disable iff (rst)
        !boot_done_r && !(otp_en && otp_valid) && eeprom_en
            && eeprom_valid && div_ok(eeprom_ctrl[9:0])
            |=> cfg_src_r == 2'b10 && pll_fb_div == $past(eeprom_ctrl[9:0]);
    endproperty
    a_boot_rom: assert property (p_boot_rom)
        else $error("boot did not take the eeprom word");

    property p_no_early_lock;
        @(posedge mclk) disable iff (rst)
        !locked_r && !vc_ok |=> !locked_r;
    endproperty
    a_no_early_lock: assert property (p_no_early_lock)
        else $error("lock declared with control voltage out of limits");

    property p_unlock_boot;
        @(posedge mclk) disable iff (rst)
        $rose(boot_done_r) |-> !locked_r && state_r == SPL_ST_WAIT;
    endproperty
    a_unlock_boot: assert property (p_unlock_boot)
        else $error("lock shown right after boot load");

    property p_bad_div;
        @(posedge mclk) disable iff (rst)
        wr_en && paddr == SPL_OFS_CTRL && boot_done_r
            && !div_ok(pwdata[SPL_CTRL_DIV_LSB +: 10])
            |=> $stable(ctrl_r) && irq_stat_r[SPL_IRQ_BADDIV];
    endproperty
    a_bad_div: assert property (p_bad_div)
        else $error("out of range divider not refused");

    property p_lock_event;
        @(posedge mclk) disable iff (rst)
        $rose(locked_r) |=> irq_stat_r[SPL_IRQ_LOCK];
    endproperty
    a_lock_event: assert property (p_lock_event)
        else $error("lock gain not flagged");

    property p_freq_m;
        @(posedge mclk) disable iff (rst)
        wr_en && paddr == SPL_OFS_FREQ_M_HI
            |=> freq_r.num[47:32] == $past(pwdata[15:0]);
    endproperty
    a_freq_m: assert property (p_freq_m)
        else $error("numerator upper part not stored");

endmodule : spl_core

`default_nettype wire

// *** include/spl_pkg.sv ***
// Purpose: constants and types for the system pll config and lock monitor
// Assumes: apb register access, 10 MHz mclk
// Notes: frequency words are numerator over denominator

package spl_pkg;

    // apb byte offsets
    localparam logic [7:0] SPL_OFS_CTRL = 8'h00;
    localparam logic [7:0] SPL_OFS_LOCK = 8'h04;
    localparam logic [7:0] SPL_OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] SPL_OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] SPL_OFS_FREQ_M_LO = 8'h10;
    localparam logic [7:0] SPL_OFS_FREQ_M_HI = 8'h14;
    localparam logic [7:0] SPL_OFS_FREQ_N = 8'h18;
    localparam logic [7:0] SPL_OFS_CFG_SRC = 8'h1c;

    // field positions in the control word
    localparam int SPL_CTRL_DIV_LSB = 0;
    localparam int SPL_CTRL_DBL_BIT = 16;
    localparam int SPL_CTRL_GPIO_BIT = 17;

    // feedback divider range and reset value
    localparam logic [9:0] SPL_FBDIV_MIN = 10'h06c;
    localparam logic [9:0] SPL_FBDIV_MAX = 10'h22c;
    localparam logic [9:0] SPL_FBDIV_RST = 10'h06c;

    // interrupt bits
    localparam int SPL_IRQ_LOL = 0;
    localparam int SPL_IRQ_LOCK = 1;
    localparam int SPL_IRQ_BADDIV = 2;

    // lock qualification time
    localparam int SPL_CLK_MHZ = 10;
    localparam int SPL_LOCK_QUAL_US = 100;
    localparam int SPL_LOCK_QUAL_CYC = SPL_LOCK_QUAL_US * SPL_CLK_MHZ;

    // control voltage code window base and span, the doubler lowers the upper limit by 12'h040
    localparam logic [11:0] SPL_VC_BASE = 12'h200;
    localparam logic [11:0] SPL_VC_SPAN = 12'h400;

    typedef struct packed {
        logic gpio_route;
        logic doubler_en;
        logic [9:0] fb_div;
    } spl_ctrl_t;

    typedef struct packed {
        logic [47:0] num;
        logic [15:0] den;
    } spl_freq_t;

    typedef enum logic [1:0] {
        SPL_ST_LOAD,
        SPL_ST_WAIT,
        SPL_ST_LOCKED
    } spl_state_t;

endpackage : spl_pkg

// *** bench/spl_pll_model.sv ***
// Purpose: loop filter voltage of the analog pll, seen by the bench
// Assumes: the loop pulls in a few cycles after each new setting
// Notes: upset pushes the voltage above the lock window
`timescale 1ns/1ps
`default_nettype none
module spl_pll_model
    import spl_pkg::*;
#(
    parameter int SETTLE = 3
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // pll settings and fault request
    input wire logic dbl,
    input wire logic [9:0] div,
    input wire logic upset,
    // loop filter voltage code
    output logic [11:0] vc_code
);
    logic [11:0] lo;
    logic [11:0] hi;
    logic [11:0] last_r;
    logic [11:0] cnt_r;
    assign lo = SPL_VC_BASE - {4'h0, div[9:2]};
    assign hi = SPL_VC_BASE + SPL_VC_SPAN - {3'h0, div[9:1]}
        - (dbl ? 12'h040 : 12'h000);
    always_ff @(posedge mclk) begin
        last_r <= {dbl, div, upset};
        if (rst || last_r != {dbl, div, upset}) cnt_r <= 12'h000;
        else if (cnt_r < SETTLE) cnt_r <= cnt_r + 12'h001;
    end
    // pulling in: drifts below the window, never a stale value
    always_comb begin
        if (upset) vc_code = hi + 12'h001;
        else if (cnt_r < SETTLE) vc_code = lo - 12'h001 - cnt_r;
        else vc_code = lo + ((hi - lo) >> 1);
    end
endmodule : spl_pll_model
`default_nettype wire

// *** bench/testbench.sv ***
// Purpose: self-checking bench for the pll config and lock monitor
// Assumes: apb slave may stretch access, master waits for pready
// Notes: lock qualification shortened to 8 cycles
`timescale 1ns/1ps
`default_nettype none
module testbench
    import spl_pkg::*;
;
    localparam logic [9:0] EDIV [4] = '{10'h06b, 10'h06c, 10'h22c, 10'h22d};
    localparam logic [7:0] FADR [3] = '{SPL_OFS_FREQ_M_LO,
        SPL_OFS_FREQ_M_HI, SPL_OFS_FREQ_N};
    localparam logic [31:0] FMSK [3] = '{32'hffffffff, 32'hffff, 32'hffff};
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, upset = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv, cur, m;
    logic [31:0] seed = 32'h863e;
    logic pready, pslverr, ev, ok;
    logic otp_en = 0, otp_valid = 0, eeprom_en = 0, eeprom_valid = 0;
    logic [11:0] otp_ctrl = 12'h0, eeprom_ctrl = 12'h0, vc_code;
    logic pll_doubler_en, fod_clk_en, lol_gpio, irq;
    logic [9:0] pll_fb_div, dv;
    int num_errors = 0, n_checks = 0, k, j;
    spl_core #(.LOCK_QUAL_CYC(8)) dut (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .otp_en(otp_en),
        .otp_valid(otp_valid), .otp_ctrl(otp_ctrl), .eeprom_en(eeprom_en),
        .eeprom_valid(eeprom_valid), .eeprom_ctrl(eeprom_ctrl),
        .vc_code(vc_code), .pll_doubler_en(pll_doubler_en),
        .pll_fb_div(pll_fb_div), .fod_clk_en(fod_clk_en),
        .lol_gpio(lol_gpio), .irq(irq)
    );
    spl_pll_model pll (
        .mclk(mclk), .rst(rst), .dbl(pll_doubler_en), .div(pll_fb_div),
        .upset(upset), .vc_code(vc_code)
    );
    initial begin
        forever #50 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h00400007 : 32'h0);
    endfunction : lfsr
    function automatic logic [31:0] ctl(logic [9:0] d, logic b, logic g);
        return {14'h0, g, b, 6'h0, d};
    endfunction : ctl
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        // data and error taken at the very edge that sees pready
        for (i = 0; i < 16; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) begin
                rv = prdata;
                ev = pslverr;
                break;
            end
        end
        if (i == 16) begin
            num_errors++;
            wrap_up();
        end
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic rd(logic [7:0] a);
        apb(0, a, 0);
    endtask : rd
    task automatic wait_lock(logic want);
        int i;
        for (i = 0; i < 40 && rv[0] !== want; i++) rd(SPL_OFS_LOCK);
        if (i == 40) begin
            num_errors++;
            wrap_up();
        end
    endtask : wait_lock
    initial begin
        // otp wins, then eeprom, then a bad otp word with no valid eeprom word gives defaults
        for (k = 0; k < 3; k++) begin
            otp_en <= 1;
            eeprom_en <= 1;
            otp_valid <= (k != 1);
            eeprom_valid <= (k != 2);
            otp_ctrl <= (k == 2) ? 12'h22d : 12'h4c8;
            eeprom_ctrl <= 12'h9f4;
            rst <= 1;
            repeat (3) @(posedge mclk);
            rst <= 0;
            repeat (2) @(posedge mclk);
            rd(SPL_OFS_LOCK);
            chk(rv, 32'h2);
            rd(SPL_OFS_CFG_SRC);
            chk(rv, (k == 2) ? 0 : k + 1);
            rd(SPL_OFS_CTRL);
            chk(rv, k == 0 ? ctl(10'h0c8, 1, 0) : k == 1 ?
                ctl(10'h1f4, 0, 1) : ctl(SPL_FBDIV_RST, 0, 0));
        end
        $display("boot test done");
        cur = ctl(SPL_FBDIV_RST, 0, 0);
        for (k = 0; k < 10; k++) begin
            seed = lfsr(seed);
            dv = (k < 4) ? EDIV[k] : SPL_FBDIV_MIN + 10'(seed[15:0] % 449);
            ok = dv >= SPL_FBDIV_MIN && dv <= SPL_FBDIV_MAX;
            apb(1, SPL_OFS_CTRL, ctl(dv, seed[20], 0));
            if (ok) begin
                cur = ctl(dv, seed[20], 0);
                rd(SPL_OFS_LOCK);
                chk(rv, 32'h2);
                chk(lol_gpio, 0);
            end else begin
                rd(SPL_OFS_IRQ_STAT);
                chk(rv & 32'h4, 32'h4);
                apb(1, SPL_OFS_IRQ_STAT, 32'h4);
            end
            rd(SPL_OFS_CTRL);
            chk(rv, cur);
            chk(pll_fb_div, cur[9:0]);
            chk(pll_doubler_en, cur[16]);
        end
        $display("divider test done");
        apb(1, SPL_OFS_CTRL, ctl(10'h0c8, 1, 1));
        rd(SPL_OFS_LOCK);
        chk(lol_gpio, 1);
        wait_lock(1);
        rd(SPL_OFS_LOCK);
        chk(rv, 32'h1);
        chk(fod_clk_en, 1);
        chk(lol_gpio, 0);
        rd(SPL_OFS_IRQ_STAT);
        chk(rv & 32'h2, 32'h2);
        apb(1, SPL_OFS_IRQ_STAT, 32'h7);
        apb(1, SPL_OFS_IRQ_MASK, 32'h1);
        rd(SPL_OFS_IRQ_STAT);
        chk(rv, 32'h0);
        chk(irq, 0);
        @(posedge mclk);
        upset <= 1;
        wait_lock(0);
        rd(SPL_OFS_LOCK);
        chk(rv, 32'h2);
        chk(lol_gpio, 1);
        chk(fod_clk_en, 0);
        rd(SPL_OFS_IRQ_STAT);
        chk(rv & 32'h1, 32'h1);
        chk(irq, 1);
        apb(1, SPL_OFS_IRQ_MASK, 32'h0);
        rd(SPL_OFS_IRQ_MASK);
        chk(irq, 0);
        @(posedge mclk);
        upset <= 0;
        wait_lock(1);
        apb(1, SPL_OFS_IRQ_STAT, 32'h7);
        rd(SPL_OFS_IRQ_STAT);
        chk(rv, 32'h0);
        $display("lock test done");
        for (k = 0; k < 9; k++) begin
            seed = lfsr(seed);
            j = k % 3;
            m = (k < 3) ? 32'hffffffff : seed;
            apb(1, FADR[j], m);
            rd(FADR[j]);
            chk(rv & FMSK[j], m & FMSK[j]);
        end
        $display("frequency word test done");
        apb(1, 8'h20, 32'h5a5a5a5a);
        chk(ev, 1);
        rd(8'h20);
        chk(ev, 1);
        chk(rv, 32'h0);
        apb(1, SPL_OFS_CFG_SRC, 32'h3);
        rd(SPL_OFS_CFG_SRC);
        chk(rv, 32'h0);
        $display("unmapped test done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
